//--- design/ofrl_pkg.sv
// Package: constants, field layouts and carrier structs for the fault response logic
package ofrl_pkg;

    // ------------------------------------------------------------
    // Command codes and register defaults
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OC_ACTION  = 8'h47;
    localparam logic [7:0] CMD_UV_ACTION  = 8'h45;
    localparam logic [7:0] OC_ACTION_RST  = 8'h00;
    localparam logic [7:0] UV_ACTION_RST  = 8'hB8;
    localparam logic [6:0] RETRY_INT_RST  = 7'h10;

    // ------------------------------------------------------------
    // Field layout of the response byte
    // ------------------------------------------------------------
    localparam int RESP_HI  = 7;
    localparam int RESP_LO  = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI   = 2;
    localparam int DLY_LO   = 0;

    localparam logic [1:0] RESP_IGNORE  = 2'h0;
    localparam logic [1:0] RESP_DEGLTCH = 2'h1;
    localparam logic [1:0] RESP_SHUT    = 2'h2;
    localparam logic [1:0] RESP_BAD     = 2'h3;
    localparam logic [2:0] RETRY_FOREVR = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 20_000_000;
    localparam int DLY_UNIT_NS  = 10_000;
    localparam int CLK_NS       = 1_000_000_000 / CLK_HZ;
    localparam int TICK_CYC     = DLY_UNIT_NS / CLK_NS;
    localparam logic [8:0] TICK_LAST = 9'(TICK_CYC - 1);
    localparam int RETRY_UNIT_CYC    = 4096;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int SB_NOTA  = 0;
    localparam int SW_VOUT  = 15;
    localparam int SV_UVF   = 4;
    localparam int SV_TON   = 2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] cmd;
        logic [7:0] data;
    } ofrl_req_s;

    typedef struct packed {
        logic        ton_delay_done;
        logic        ton_rise_done;
        logic        ton_max_reached;
        logic        uv_thr_reached;
        logic        oc_present;
        logic        ramping;
        logic        active;
    } ofrl_seq_s;

    typedef struct packed {
        logic [7:0]  status_byte;
        logic [15:0] status_word;
        logic [7:0]  status_vout;
    } ofrl_stat_s;

    function automatic logic [1:0] resp_of(input logic [7:0] b);
        return b[RESP_HI:RESP_LO];
    endfunction

    function automatic logic [2:0] retry_of(input logic [7:0] b);
        return b[RETRY_HI:RETRY_LO];
    endfunction

endpackage

//--- design/ofrl_tick.sv
// Prescaler producing one pulse per 10 us delay unit
`timescale 1ns/1ns
module ofrl_tick (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    output logic      tick_out
);
    logic [8:0] cnt_ff;
    wire        at_last = (cnt_ff == ofrl_pkg::TICK_LAST);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff   <= 9'h000;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            cnt_ff   <= at_last ? 9'h000 : cnt_ff + 9'h001;
            tick_out <= at_last;
        end
    end
endmodule

//--- design/ofrl_deglitch.sv
// Deglitch delay counter for the delayed shutdown response
`timescale 1ns/1ns
module ofrl_deglitch (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       tick_in,
    input  wire logic       fault_in,
    input  wire logic [2:0] delay_in,
    output logic            expired_out
);
    logic [2:0] cnt_ff;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff      <= 3'h0;
            expired_out <= 1'b0;
        end else if (ce_in) begin
            if (!fault_in) begin
                cnt_ff      <= 3'h0;
                expired_out <= 1'b0;
            end else if (cnt_ff >= delay_in) begin
                expired_out <= 1'b1;
            end else if (tick_in) begin
                cnt_ff <= cnt_ff + 3'h1;
            end
        end
    end
endmodule

//--- design/ofrl_top.sv
// Per-channel output undervoltage and turn-on timeout fault response logic
// Overview of operation
// - UV fault sets VOUT summary and UV status bits and asserts alert.
// - UV detection masked until delay, rise, timeout, threshold done, no overcurrent.
// - UV detection masked whenever the channel is inactive.
// - UV detection masked during ramp-up and ramp-down sequencing.
// - Response 00 keeps running; only flags and alerts.
// - Response 01 runs for delay, then acts per retry field if still faulted.
// - Response 10 disables output at once, then acts per retry field.
// - Writing response 11 raises a CML fault.
// - Retry 000-110 stays off until commanded off or bias removed.
// - Retry 111 restarts forever at the retry interval until commanded off.
// - Delay field counts 10us steps, deglitched response only.
// - UV and timeout fault bits hold until clear-faults, off-then-on, or bias cycle; CML fault until clear-faults or bias cycle.
// - UV response configuration taken as a single byte write.
// - Timeout fault sets none-of-above, VOUT summary, timeout bits; asserts alert.
// - Timeout response value zero disables that response.
// - Overcurrent response byte at 0x47, read/write, default 0x00.
`timescale 1ns/1ns
module ofrl_top (
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 ce_in,
    input  wire ofrl_pkg::ofrl_req_s  req_in,
    input  wire logic                 clear_faults_in,
    input  wire logic                 channel_run_pin_in,
    input  wire logic                 op_on_in,
    input  wire ofrl_pkg::ofrl_seq_s  seq_in,
    input  wire logic                 uv_raw_in,
    input  wire logic                 ton_timeout_in,
    input  wire logic [7:0]           ton_action_in,
    input  wire logic [6:0]           restart_interval_setting_in,
    output ofrl_pkg::ofrl_stat_s      stat_out,
    output logic [7:0]                rd_data_out,
    output logic                      cml_fault_out,
    output logic                      alert_n_out,
    output logic                      out_enable_out,
    output logic                      restart_req_out
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_SHUT  = 4'h2,
        ST_WAIT  = 4'h4,
        ST_LATCH = 4'h8
    } ofrl_st_e;

    ofrl_st_e    st_ff;
    ofrl_st_e    nxt_st;
    logic [7:0]  uv_cfg_ff;
    logic [7:0]  oc_cfg_ff;
    logic        uv_flag_ff;
    logic        ton_flag_ff;
    logic        on_ff;
    logic        cml_ff;
    logic [18:0] retry_cnt_ff;
    logic        tick;
    logic        dg_expired;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire on_cmd      = channel_run_pin_in & op_on_in;
    wire on_rise     = on_cmd & ~on_ff;
    wire flag_clr    = clear_faults_in | on_rise;
    wire wr_uv       = req_in.wr & (req_in.cmd == ofrl_pkg::CMD_UV_ACTION);
    wire wr_oc       = req_in.wr & (req_in.cmd == ofrl_pkg::CMD_OC_ACTION);
    wire wr_uv_bad   = wr_uv & (ofrl_pkg::resp_of(req_in.data) == ofrl_pkg::RESP_BAD);
    wire [1:0] resp  = ofrl_pkg::resp_of(uv_cfg_ff);
    wire [2:0] retry = ofrl_pkg::retry_of(uv_cfg_ff);
    wire [2:0] dly   = uv_cfg_ff[ofrl_pkg::DLY_HI:ofrl_pkg::DLY_LO];

    wire uv_ready    = seq_in.ton_delay_done & seq_in.ton_rise_done &
                       seq_in.ton_max_reached & seq_in.uv_thr_reached & ~seq_in.oc_present;
    wire uv_unmask   = uv_ready & seq_in.active & ~seq_in.ramping;
    wire uv_fault    = uv_raw_in & uv_unmask & (st_ff == ST_RUN);
    wire ton_fault   = ton_timeout_in & (ton_action_in != 8'h00);

    wire [18:0] retry_len = 19'(restart_interval_setting_in) * 19'(ofrl_pkg::RETRY_UNIT_CYC);
    wire retry_done  = (retry_cnt_ff >= retry_len);
    wire uv_trip_now = (resp == ofrl_pkg::RESP_SHUT) & uv_fault;
    wire uv_trip_dly = (resp == ofrl_pkg::RESP_DEGLTCH) & dg_expired;
    wire uv_trip     = uv_trip_now | uv_trip_dly;

    // ------------------------------------------------------------
    // Response state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_RUN: begin
                if (on_cmd && uv_trip) begin
                    nxt_st = ST_SHUT;
                end
            end
            ST_SHUT: begin
                nxt_st = (retry == ofrl_pkg::RETRY_FOREVR) ? ST_WAIT : ST_LATCH;
            end
            ST_WAIT: begin
                if (retry_done) begin
                    nxt_st = ST_RUN;
                end
            end
            ST_LATCH: begin
                nxt_st = ST_LATCH;
            end
            default: begin
                nxt_st = ST_RUN;
            end
        endcase
        if (!on_cmd) begin
            nxt_st = ST_RUN;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff        <= ST_RUN;
            retry_cnt_ff <= 19'h00000;
            on_ff        <= 1'b0;
        end else if (ce_in) begin
            st_ff        <= nxt_st;
            retry_cnt_ff <= (st_ff == ST_WAIT) ? retry_cnt_ff + 19'h00001 : 19'h00000;
            on_ff        <= on_cmd;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            uv_cfg_ff <= ofrl_pkg::UV_ACTION_RST;
            oc_cfg_ff <= ofrl_pkg::OC_ACTION_RST;
        end else if (ce_in) begin
            if (wr_uv && !wr_uv_bad) begin
                uv_cfg_ff <= req_in.data;
            end
            if (wr_oc) begin
                oc_cfg_ff <= req_in.data;
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            uv_flag_ff  <= 1'b0;
            ton_flag_ff <= 1'b0;
            cml_ff      <= 1'b0;
        end else if (ce_in) begin
            uv_flag_ff  <= uv_fault | (uv_flag_ff & ~flag_clr);
            ton_flag_ff <= ton_fault | (ton_flag_ff & ~flag_clr);
            cml_ff      <= wr_uv_bad | (cml_ff & ~clear_faults_in);
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    wire [7:0] rd_mux = (req_in.cmd == ofrl_pkg::CMD_UV_ACTION) ? uv_cfg_ff :
                        (req_in.cmd == ofrl_pkg::CMD_OC_ACTION) ? oc_cfg_ff : 8'h00;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stat_out        <= '0;
            rd_data_out     <= 8'h00;
            cml_fault_out   <= 1'b0;
            alert_n_out     <= 1'b1;
            out_enable_out  <= 1'b0;
            restart_req_out <= 1'b0;
        end else if (ce_in) begin
            stat_out.status_byte <= 8'(ton_flag_ff) << ofrl_pkg::SB_NOTA;
            stat_out.status_word <= 16'(uv_flag_ff | ton_flag_ff) << ofrl_pkg::SW_VOUT;
            stat_out.status_vout <= (8'(uv_flag_ff) << ofrl_pkg::SV_UVF) |
                                    (8'(ton_flag_ff) << ofrl_pkg::SV_TON);
            if (req_in.rd) begin
                rd_data_out <= rd_mux;
            end
            cml_fault_out   <= cml_ff;
            alert_n_out     <= ~(uv_flag_ff | ton_flag_ff | cml_ff);
            out_enable_out  <= on_cmd & (nxt_st == ST_RUN);
            restart_req_out <= (st_ff == ST_WAIT) & retry_done;
        end
    end

    ofrl_tick u_tick (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .ce_in    (ce_in),
        .tick_out (tick)
    );

    ofrl_deglitch u_dg (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .tick_in     (tick),
        .fault_in    (uv_fault & (resp == ofrl_pkg::RESP_DEGLTCH)),
        .delay_in    (dly),
        .expired_out (dg_expired)
    );
endmodule

//--- dv/ofrl_checker.sv
// Port-level assertions for the fault response logic
`timescale 1ns/1ns
module ofrl_checker (
    input wire logic                clk_in,
    input wire logic                rst_in,
    input wire logic                ce_in,
    input wire ofrl_pkg::ofrl_req_s req_in,
    input wire logic                clear_faults_in,
    input wire logic                channel_run_pin_in,
    input wire logic                op_on_in,
    input wire ofrl_pkg::ofrl_seq_s seq_in,
    input wire logic                uv_raw_in,
    input wire logic                ton_timeout_in,
    input wire logic [7:0]          ton_action_in,
    input wire logic [6:0]          restart_interval_setting_in,
    input wire ofrl_pkg::ofrl_stat_s stat_out,
    input wire logic [7:0]          rd_data_out,
    input wire logic                cml_fault_out,
    input wire logic                alert_n_out,
    input wire logic                out_enable_out,
    input wire logic                restart_req_out
);
    // ------------------------------------------------------------
    // Shadow configuration and unmask age
    // ------------------------------------------------------------
    logic [7:0] uv_cfg_ff;
    logic [7:0] oc_cfg_ff;
    logic [1:0] open_age_ff;
    wire logic run_on = channel_run_pin_in && op_on_in;
    wire logic wr_uv  = ce_in && req_in.wr && req_in.cmd == 8'h45 && req_in.data[7:6] != 2'h3;
    wire logic wr_oc  = ce_in && req_in.wr && req_in.cmd == 8'h47;
    wire logic uvf    = stat_out.status_vout[4];
    wire logic uv_open = uv_raw_in && seq_in.active && !seq_in.ramping && !seq_in.oc_present
                         && seq_in.uv_thr_reached && seq_in.ton_max_reached
                         && seq_in.ton_delay_done && seq_in.ton_rise_done;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            uv_cfg_ff   <= 8'hB8;
            oc_cfg_ff   <= 8'h00;
            open_age_ff <= 2'h3;
        end else begin
            if (wr_uv) uv_cfg_ff <= req_in.data;
            if (wr_oc) oc_cfg_ff <= req_in.data;
            if (uv_open) open_age_ff <= 2'h0;
            else if (open_age_ff != 2'h3) open_age_ff <= open_age_ff + 2'h1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence uv_rise;
        $rose(uvf);
    endsequence
    sequence bad_wr;
        ce_in && req_in.wr && req_in.cmd == 8'h45 && req_in.data[7:6] == 2'h3;
    endsequence
    uv_open_a: assert property (uv_rise |-> open_age_ff != 2'h3)
        else $error("uv flag set while masked");
    uv_alert_a: assert property (uvf |-> stat_out.status_word[15] && !alert_n_out)
        else $error("uv flag without summary or alert");
    ton_flag_a: assert property (stat_out.status_vout[2] |-> stat_out.status_byte[0]
        && stat_out.status_word[15] && !alert_n_out) else $error("timeout flags incomplete");
    ton_off_a: assert property ($rose(stat_out.status_vout[2]) |-> $past(ton_action_in, 2) != 8'h00)
        else $error("timeout flagged with response zero");
    shut_now_a: assert property (uv_rise and uv_cfg_ff[7:6] == 2'h2 |-> !out_enable_out)
        else $error("output not disabled on shutdown response");
    cml_bad_a: assert property (bad_wr |-> ##2 cml_fault_out)
        else $error("bad response write without cml");
    oc_read_a: assert property (ce_in && req_in.rd && req_in.cmd == 8'h47
        |=> rd_data_out == oc_cfg_ff) else $error("overcurrent byte read wrong");
    latch_off_a: assert property (!out_enable_out && uvf && uv_cfg_ff[5:3] != 3'h7
        && run_on && $past(run_on) |=> !out_enable_out) else $error("restart without retry");
    ignore_run_a: assert property (uv_cfg_ff[7:6] == 2'h0 && run_on && out_enable_out
        |=> out_enable_out) else $error("output dropped under ignore response");
    restart_ok_a: assert property (restart_req_out |-> uv_cfg_ff[5:3] == 3'h7
        ##1 !restart_req_out) else $error("bad restart pulse");
endmodule

bind ofrl_top ofrl_checker i_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .req_in(req_in), .clear_faults_in(clear_faults_in), .channel_run_pin_in(channel_run_pin_in),
    .op_on_in(op_on_in), .seq_in(seq_in), .uv_raw_in(uv_raw_in), .ton_timeout_in(ton_timeout_in),
    .ton_action_in(ton_action_in), .restart_interval_setting_in(restart_interval_setting_in),
    .stat_out(stat_out), .rd_data_out(rd_data_out), .cml_fault_out(cml_fault_out),
    .alert_n_out(alert_n_out), .out_enable_out(out_enable_out), .restart_req_out(restart_req_out));

//--- dv/ofrl_host.sv
// Host model issuing single byte command reads and writes
`timescale 1ns/1ns
module ofrl_host (
    input  wire logic           clk_in,
    input  wire logic [7:0]     rd_data_in,
    output ofrl_pkg::ofrl_req_s req_out
);
    initial req_out = '0;
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(negedge clk_in);
        req_out = '{wr: 1'b1, rd: 1'b0, cmd: c, data: d};
        @(negedge clk_in);
        req_out = '{wr: 1'b0, rd: 1'b0, cmd: ~c, data: ~d};
    endtask
    task automatic rd(input logic [7:0] c, output logic [7:0] d);
        @(negedge clk_in);
        req_out = '{wr: 1'b0, rd: 1'b1, cmd: c, data: 8'h00};
        @(negedge clk_in);
        req_out = '{wr: 1'b0, rd: 1'b0, cmd: ~c, data: 8'hFF};
        d = rd_data_in;
    endtask
endmodule

//--- dv/ofrl_top_tb.sv
// Self-checking testbench for the fault response logic
`timescale 1ns/1ns
module ofrl_top_tb;
    logic                 clk_in = 1'b0;
    logic                 rst_in = 1'b1;
    logic                 ce = 1'b1;
    logic                 clr = 1'b0, run = 1'b0, op = 1'b0, uv = 1'b0, ton = 1'b0;
    logic [7:0]           ton_act = 8'h00;
    logic [6:0]           rint = 7'h01;
    ofrl_pkg::ofrl_seq_s  seq = '0;
    ofrl_pkg::ofrl_req_s  req;
    ofrl_pkg::ofrl_stat_s stat;
    logic [7:0]           rdat, d;
    logic                 cml, alert_n, oen, rreq;
    int                   fail_count = 0;
    int                   checks_done = 0;
    int                   n;
    always #25 clk_in = ~clk_in;
    ofrl_host i_host (.clk_in(clk_in), .rd_data_in(rdat), .req_out(req));
    ofrl_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .req_in(req),
        .clear_faults_in(clr), .channel_run_pin_in(run), .op_on_in(op), .seq_in(seq),
        .uv_raw_in(uv), .ton_timeout_in(ton), .ton_action_in(ton_act),
        .restart_interval_setting_in(rint), .stat_out(stat), .rd_data_out(rdat),
        .cml_fault_out(cml), .alert_n_out(alert_n), .out_enable_out(oen), .restart_req_out(rreq));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_in);
    endtask
    task automatic pulse_clr();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(2);
    endtask
    initial begin
        #3_000_000;
        fail_count++;
        final_report();
    end
    initial begin
        cyc(5);
        rst_in = 1'b0;
        i_host.rd(8'h47, d);
        check("oc reset", d, 8'h00);
        i_host.rd(8'h45, d);
        check("uv reset", d, ofrl_pkg::UV_ACTION_RST);
        i_host.rd(8'h10, d);
        check("unmapped", d, 8'h00);
        i_host.wr(8'h47, 8'hA5);
        i_host.rd(8'h47, d);
        check("oc rw", d, 8'hA5);
        ce = 1'b0;
        i_host.wr(8'h47, 8'h5A);
        ce = 1'b1;
        i_host.rd(8'h47, d);
        check("oc frozen", d, 8'hA5);
        i_host.wr(8'h45, 8'hC0);
        cyc(2);
        check("cml", cml, 1'b1);
        i_host.rd(8'h45, d);
        check("uv kept", d, ofrl_pkg::UV_ACTION_RST);
        pulse_clr();
        check("cml clr", cml, 1'b0);
        seq = ofrl_pkg::ofrl_seq_s'(7'h79);
        run = 1'b1;
        op = 1'b1;
        cyc(5);
        check("on", oen, 1'b1);
        for (n = 0; n < 7; n++) begin
            seq = ofrl_pkg::ofrl_seq_s'(7'h79 ^ (7'h01 << n));
            uv = 1'b1;
            cyc(10);
            check("masked", stat.status_vout[4], 1'b0);
            uv = 1'b0;
        end
        seq = ofrl_pkg::ofrl_seq_s'(7'h79);
        i_host.wr(8'h45, 8'h00);
        uv = 1'b1;
        cyc(3);
        check("uv flag", {stat.status_word[15], stat.status_vout[4], alert_n}, 3'h6);
        cyc(20);
        check("ignore", oen, 1'b1);
        uv = 1'b0;
        cyc(2);
        check("sticky", stat.status_vout[4], 1'b1);
        pulse_clr();
        check("cleared", {stat.status_vout[4], alert_n}, 2'h1);
        i_host.wr(8'h45, 8'h42);
        for (n = 0; n < 3; n++) begin
            uv = 1'b1;
            cyc(150);
            uv = 1'b0;
            cyc(5);
        end
        check("glitch", oen, 1'b1);
        uv = 1'b1;
        cyc(190);
        check("delay run", oen, 1'b1);
        cyc(230);
        check("delay off", oen, 1'b0);
        uv = 1'b0;
        cyc(600);
        check("latched", oen, 1'b0);
        run = 1'b0;
        cyc(3);
        run = 1'b1;
        cyc(5);
        check("rerun", {stat.status_vout[4], oen}, 2'h1);
        i_host.wr(8'h45, 8'hB8);
        uv = 1'b1;
        cyc(3);
        check("shut", oen, 1'b0);
        uv = 1'b0;
        n = 0;
        while (rreq !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
        check("restart", rreq, 1'b1);
        check("retry gap", (n > 4090 && n < 4100), 1'b1);
        check("restarted", oen, 1'b1);
        pulse_clr();
        ton = 1'b1;
        cyc(1);
        ton = 1'b0;
        cyc(3);
        check("ton zero", stat.status_vout[2], 1'b0);
        ton_act = 8'h01;
        ton = 1'b1;
        cyc(1);
        ton = 1'b0;
        cyc(3);
        check("ton", {stat.status_byte[0], stat.status_word[15], stat.status_vout[2], alert_n},
              4'hE);
        final_report();
    end
endmodule
